//--- verilog/cdv_top.sv
/*
 * cdv_top: configurable clock dividers and primary phase select.
 * Assumes the reference clock and the four oscillator phases arrive as
 * pins from outside clk's domain and are oversampled by clk, so every
 * divided clock is a registered level on clk. Registers sit on a plain
 * strobe port with read data one cycle after the read strobe.
 */
// The register offsets and the plain strobed port are this design's own decisions.
// What this block does
// - bits 30:29 pick primary phase output; bit 31 is ignored
// - secondary 2 divides by bits 28:24 plus one
// - secondary 1 divides by bits 23:19 plus one
// - primary divides by bits 18:14 plus one
// - loop feedback divides by bits 13:7 plus one
// - reference divides by bits 6:0 plus one
module cdv_top #(
   parameter logic [31:0] CFG_INIT = cdv_pkg::CFG_RESET   // configuration after reset
) (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic [cdv_pkg::ADDR_W-1:0]  addr,
   input  wire logic [cdv_pkg::DATA_W-1:0]  wr_data,
   input  wire logic                        wr_en,
   input  wire logic                        rd_en,
   output logic      [cdv_pkg::DATA_W-1:0]  rd_data,
   input  wire logic                        reference_clock_in,
   input  wire logic [3:0]                  phase_in,
   output logic                             loop_reference_clock,
   output logic                             loop_feedback_clock,
   output logic                             primary_global_clock,
   output logic                             secondary1_global_clock,
   output logic                             secondary1_core_clock,
   output logic                             secondary2_global_clock,
   output logic                             secondary2_core_clock
);

   localparam int NP = cdv_pkg::NUM_PINS;
   localparam int ND = cdv_pkg::NUM_DIV;
   localparam int CW = cdv_pkg::CNT_W;

   // terminal count of one divider taken from the configuration word
   function automatic logic [CW-1:0] div_term(input logic [31:0] cfg, input int idx);
      logic [CW-1:0] t;                     // field widened to the counter width
      t = '0;
      unique case (idx)
         cdv_pkg::DIV_REF:  t = CW'(cfg[cdv_pkg::REF_LSB +: cdv_pkg::REF_W]);
         cdv_pkg::DIV_FB:   t = CW'(cfg[cdv_pkg::FB_LSB +: cdv_pkg::FB_W]);
         cdv_pkg::DIV_PRIM: t = CW'(cfg[cdv_pkg::PRIM_LSB +: cdv_pkg::PRIM_W]);
         cdv_pkg::DIV_SEC1: t = CW'(cfg[cdv_pkg::SEC1_LSB +: cdv_pkg::SEC1_W]);
         default:           t = CW'(cfg[cdv_pkg::SEC2_LSB +: cdv_pkg::SEC2_W]);
      endcase
      return t;
   endfunction : div_term

   // configuration and register port
   logic [31:0]             cfg_q;        // configuration word
   logic [31:0]             cfg_d;
   logic [31:0]             rd_data_d;    // read answer for the next cycle
   logic [1:0]              phase_idx;    // effective primary phase

   // only the low two select bits matter: there are four phases
   assign phase_idx = cfg_q[cdv_pkg::SEL_LSB +: 2];

   // software writes the configuration word; status is read-only
   always_comb begin
      cfg_d = cfg_q;
      if (wr_en && (addr == cdv_pkg::CFG_OFF)) begin
         cfg_d = wr_data;
      end
   end

   // read mux, zero when idle or unmapped
   always_comb begin
      rd_data_d = 32'h00000000;
      if (rd_en) begin
         unique case (addr)
            cdv_pkg::CFG_OFF:  rd_data_d = cfg_q;
            cdv_pkg::STAT_OFF: begin
               rd_data_d[cdv_pkg::STAT_SEL_LSB +: 2] = phase_idx;
               rd_data_d[6:0] = {secondary2_core_clock, secondary2_global_clock,
                                 secondary1_core_clock, secondary1_global_clock,
                                 primary_global_clock, loop_feedback_clock,
                                 loop_reference_clock};
            end
            default:           rd_data_d = 32'h00000000;
         endcase
      end
   end

   // register port state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_q   <= CFG_INIT;
         rd_data <= 32'h00000000;
      end else begin
         cfg_q   <= cfg_d;
         rd_data <= rd_data_d;
      end
   end

   // pin synchronisers
   logic [NP-1:0]           pin_s1_q;     // first stage, read by stage two only
   logic [NP-1:0]           pin_s2_q;
   logic [NP-1:0]           pin_s3_q;
   logic [NP-1:0]           lvl_q;        // accepted pin levels
   logic [NP-1:0]           lvl_d;
   logic [NP-1:0]           agree;        // stages two and three match
   logic [NP-1:0]           rise;         // accepted rising edge, one cycle

   // a change counts once stages two and three agree
   always_comb begin
      agree = ~(pin_s2_q ^ pin_s3_q);
      lvl_d = (agree & pin_s3_q) | (~agree & lvl_q);
      rise  = lvl_d & ~lvl_q;
   end

   // three-flop chain plus accepted level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
         lvl_q    <= '0;
      end else begin
         pin_s1_q <= {phase_in, reference_clock_in};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         lvl_q    <= lvl_d;
      end
   end

   // divider sources
   logic [ND-1:0]           src_lvl;      // level feeding each divider
   logic [ND-1:0]           src_rise;     // rising edge feeding each divider
   logic [2:0]              sel_pin;      // pin index of chosen phase

   always_comb begin
      sel_pin = 3'({1'b0, phase_idx} + 3'h1);
      src_lvl[cdv_pkg::DIV_REF]   = lvl_d[0];
      src_rise[cdv_pkg::DIV_REF]  = rise[0];
      // loop feedback and the secondaries follow phase zero
      src_lvl[cdv_pkg::DIV_FB]    = lvl_d[1];
      src_rise[cdv_pkg::DIV_FB]   = rise[1];
      src_lvl[cdv_pkg::DIV_PRIM]  = lvl_d[sel_pin];
      src_rise[cdv_pkg::DIV_PRIM] = rise[sel_pin];
      src_lvl[cdv_pkg::DIV_SEC1]  = lvl_d[1];
      src_rise[cdv_pkg::DIV_SEC1] = rise[1];
      src_lvl[cdv_pkg::DIV_SEC2]  = lvl_d[1];
      src_rise[cdv_pkg::DIV_SEC2] = rise[1];
   end

   // dividers
   logic [CW-1:0]           term [ND];    // terminal count per divider
   logic [CW-1:0]           cnt_q [ND];   // source edges since last pulse
   logic [CW-1:0]           cnt_d [ND];
   logic [ND-1:0]           out_d;        // next divided level

   // reload at terminal count, pulse on count zero
   always_comb begin
      for (int i = 0; i < ND; i++) begin
         term[i]  = div_term(cfg_q, i);
         cnt_d[i] = cnt_q[i];
         if (src_rise[i]) begin
            // a lowered field also wraps a counter already past it
            if (cnt_q[i] >= term[i]) begin
               cnt_d[i] = '0;
            end else begin
               cnt_d[i] = cnt_q[i] + CW'(1);
            end
         end
         // high for one source high phase in every term+1 periods
         out_d[i] = src_lvl[i] & (cnt_d[i] == '0);
      end
   end

   // divider counters and clock outputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < ND; i++) begin
            cnt_q[i] <= '0;
         end
         loop_reference_clock    <= 1'b0;
         loop_feedback_clock     <= 1'b0;
         primary_global_clock    <= 1'b0;
         secondary1_global_clock <= 1'b0;
         secondary1_core_clock   <= 1'b0;
         secondary2_global_clock <= 1'b0;
         secondary2_core_clock   <= 1'b0;
      end else begin
         for (int i = 0; i < ND; i++) begin
            cnt_q[i] <= cnt_d[i];
         end
         loop_reference_clock    <= out_d[cdv_pkg::DIV_REF];
         loop_feedback_clock     <= out_d[cdv_pkg::DIV_FB];
         primary_global_clock    <= out_d[cdv_pkg::DIV_PRIM];
         secondary1_global_clock <= out_d[cdv_pkg::DIV_SEC1];
         secondary1_core_clock   <= out_d[cdv_pkg::DIV_SEC1];
         secondary2_global_clock <= out_d[cdv_pkg::DIV_SEC2];
         secondary2_core_clock   <= out_d[cdv_pkg::DIV_SEC2];
      end
   end

   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // helper copies of per-divider state for properties
   logic [CW-1:0]           cnt_ref;
   logic [CW-1:0]           cnt_fb;
   logic [CW-1:0]           cnt_prim;
   logic [CW-1:0]           cnt_sec1;
   logic [CW-1:0]           cnt_sec2;
   logic [CW-1:0]           term_ref;
   logic [CW-1:0]           term_fb;
   logic [CW-1:0]           term_prim;
   logic [2:0]              sel_seen;     // pin index of the phase in use

   assign cnt_ref   = cnt_q[cdv_pkg::DIV_REF];
   assign cnt_fb    = cnt_q[cdv_pkg::DIV_FB];
   assign cnt_prim  = cnt_q[cdv_pkg::DIV_PRIM];
   assign cnt_sec1  = cnt_q[cdv_pkg::DIV_SEC1];
   assign cnt_sec2  = cnt_q[cdv_pkg::DIV_SEC2];
   assign term_ref  = term[cdv_pkg::DIV_REF];
   assign term_fb   = term[cdv_pkg::DIV_FB];
   assign term_prim = term[cdv_pkg::DIV_PRIM];
   assign sel_seen  = 3'({1'b0, cfg_q[cdv_pkg::SEL_LSB +: 2]} + 3'h1);

   phase_route_a: assert property (
      (cnt_prim == '0) ##1 ($stable(cfg_q) && term_prim == '0)
         |-> primary_global_clock == lvl_q[$past(sel_seen)])
      else $error("primary clock does not follow the selected phase");

   sec2_pulse_a: assert property (
      $rose(secondary2_global_clock) |-> $past(rise[1]) && secondary2_core_clock)
      else $error("secondary 2 pulse without a phase edge");

   sec1_hold_a: assert property (
      !rise[1] |=> $stable(cnt_sec1))
      else $error("secondary 1 counter moved without a source edge");

   prim_zero_a: assert property (
      primary_global_clock |-> cnt_prim == '0)
      else $error("primary pulse away from count zero");

   fb_count_a: assert property (
      (src_rise[cdv_pkg::DIV_FB] && cnt_fb < term_fb) |=> cnt_fb == $past(cnt_fb) + CW'(1))
      else $error("feedback counter failed to advance");

   ref_wrap_a: assert property (
      (rise[0] && cnt_ref >= term_ref) |=> cnt_ref == '0)
      else $error("reference counter failed to reload");

   pass_through_a: assert property (
      (cnt_ref == '0) ##1 ($stable(cfg_q) && term_ref == '0) |-> loop_reference_clock == lvl_q[0])
      else $error("zero field does not pass the reference through");

   cfg_write_a: assert property (
      (wr_en && addr == cdv_pkg::CFG_OFF) |=> cfg_q == $past(wr_data))
      else $error("configuration write did not land");

   stat_phase_a: assert property (
      (rd_en && addr == cdv_pkg::STAT_OFF) |=> rd_data[cdv_pkg::STAT_SEL_LSB +: 2] == $past(phase_idx))
      else $error("status shows the wrong phase index");

   sec2_zero_a: assert property (
      secondary2_global_clock |-> cnt_sec2 == '0)
      else $error("secondary 2 pulse away from count zero");

   sec2_hold_a: assert property (
      !rise[1] |=> $stable(cnt_sec2))
      else $error("secondary 2 counter moved without a source edge");

   sec1_zero_a: assert property (
      secondary1_global_clock |-> cnt_sec1 == '0)
      else $error("secondary 1 pulse away from count zero");

   prim_wrap_a: assert property (
      (src_rise[cdv_pkg::DIV_PRIM] && cnt_prim >= term_prim) |=> cnt_prim == '0)
      else $error("primary counter failed to reload");

   prim_hold_a: assert property (
      !src_rise[cdv_pkg::DIV_PRIM] |=> $stable(cnt_prim))
      else $error("primary counter moved without a source edge");

   fb_zero_a: assert property (
      loop_feedback_clock |-> cnt_fb == '0)
      else $error("feedback pulse away from count zero");

   ref_zero_a: assert property (
      loop_reference_clock |-> cnt_ref == '0)
      else $error("reference pulse away from count zero");

   ref_count_a: assert property (
      (rise[0] && cnt_ref < term_ref) |=> cnt_ref == $past(cnt_ref) + CW'(1))
      else $error("reference counter failed to advance");

   // main scenarios
   cfg_write_c:   cover property (wr_en && addr == cdv_pkg::CFG_OFF);
   ref_divide_c:  cover property (term_ref > CW'(1) && rise[0] && cnt_ref == term_ref);
   phase_three_c: cover property (phase_idx == 2'h3 ##1 $rose(primary_global_clock));
   stat_read_c:   cover property (rd_en && addr == cdv_pkg::STAT_OFF);
   sel_high_c:    cover property (wr_en && addr == cdv_pkg::CFG_OFF && wr_data[31]);

endmodule : cdv_top

//--- verilog/cdv_pkg.sv
/*
 * cdv_pkg: constants for the clock divider and phase-select block.
 * Holds register offsets, configuration field layout, reset values and
 * the divider index map. Assumes a 32-bit register port with byte offsets.
 */
package cdv_pkg;

   // register port geometry
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 32;
   localparam logic [7:0]  CFG_OFF       = 8'h00;        // configuration word
   localparam logic [7:0]  STAT_OFF      = 8'h04;        // live status word
   localparam logic [31:0] CFG_RESET     = 32'h00000000; // every divider passes through

   // configuration word fields
   localparam int          SEL_LSB       = 29;           // primary phase select
   localparam int          SEL_W         = 3;
   localparam int          SEC2_LSB      = 24;           // secondary 2 divider
   localparam int          SEC2_W        = 5;
   localparam int          SEC1_LSB      = 19;           // secondary 1 divider
   localparam int          SEC1_W        = 5;
   localparam int          PRIM_LSB      = 14;           // primary divider
   localparam int          PRIM_W        = 5;
   localparam int          FB_LSB        = 7;            // loop feedback divider
   localparam int          FB_W          = 7;
   localparam int          REF_LSB       = 0;            // reference input divider
   localparam int          REF_W         = 7;

   // divider counters
   localparam int          CNT_W         = 7;
   localparam int          NUM_DIV       = 5;
   localparam int          DIV_REF       = 0;
   localparam int          DIV_FB        = 1;
   localparam int          DIV_PRIM      = 2;
   localparam int          DIV_SEC1      = 3;
   localparam int          DIV_SEC2      = 4;

   // status word field and synchroniser pin count
   localparam int          STAT_SEL_LSB  = 8;            // effective phase index
   localparam int          NUM_PINS      = 5;            // reference plus four phases

endpackage : cdv_pkg

//--- tb/cdv_osc_model.sv
/*
 * cdv_osc_model: free-running oscillator phases and reference pin.
 * Assumes a 16-cycle source period at 125 MHz; edges sit off clk edges.
 */
module cdv_osc_model (
   output logic       reference_clock_in,   // reference pin
   output logic [3:0] phase_in              // four quarter-spaced phases
);
   timeunit 1ns;
   timeprecision 100ps;
   int step;                                // quarter-period step, 0..3

   // reference: 128 ns period, 50 % duty, runs free
   initial begin
      reference_clock_in = 1'b0;
      #5;
      forever #64 reference_clock_in = ~reference_clock_in;
   end

   // phase k lags phase 0 by k quarters of the period
   initial begin
      phase_in = 4'h0;
      step = 0;
      #3;
      forever begin
         for (int k = 0; k < 4; k++) phase_in[k] = (((step - k + 4) % 4) < 2);
         #32 step = (step + 1) % 4;
      end
   end
endmodule : cdv_osc_model

//--- tb/tb_cdv_top.sv
/*
 * tb_cdv_top: register and divider checks for cdv_top.
 * Assumes the oscillator model above; every interval is counted in clk cycles.
 */
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tb_cdv_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wr_data = 32'h00000000, rd_data, got;
   logic        reference_clock_in;
   logic [3:0]  phase_in;
   logic [6:0]  outs;                       // all divided outputs in one vector
   int          bad_count = 0, num_checks = 0, cyc = 0, d0, dk;

   always #4 clk = ~clk;

   cdv_osc_model u_cdv_osc_model (.reference_clock_in(reference_clock_in), .phase_in(phase_in));
   cdv_top u_cdv_top (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .reference_clock_in(reference_clock_in), .phase_in(phase_in),
      .loop_reference_clock(outs[0]), .loop_feedback_clock(outs[1]), .primary_global_clock(outs[2]),
      .secondary1_global_clock(outs[3]), .secondary1_core_clock(outs[4]),
      .secondary2_global_clock(outs[5]), .secondary2_core_clock(outs[6]));

   // hang guard: counts as a mismatch
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         wrap_up();
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_en <= 1'b1; addr <= a; wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd_en <= 1'b1; addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask : rd

   // wait for one output to go low, then high
   task automatic rise(input int i);
      do begin @(posedge clk); #1; end while (outs[i] !== 1'b0);
      do begin @(posedge clk); #1; end while (outs[i] !== 1'b1);
   endtask : rise

   // steady interval between output rises, in cycles
   task automatic meas(input int i, input int n);
      time t0;
      repeat (2) rise(i);
      t0 = $time;
      rise(i);
      `CHK("interval", 16 * (n + 1), int'(($time - t0) / 8))
   endtask : meas

   function automatic logic [31:0] mk(int sel, int s2, int s1, int pr, int fb, int rf);
      return (32'(sel) << cdv_pkg::SEL_LSB) | (32'(s2) << cdv_pkg::SEC2_LSB) |
             (32'(s1) << cdv_pkg::SEC1_LSB) | (32'(pr) << cdv_pkg::PRIM_LSB) |
             (32'(fb) << cdv_pkg::FB_LSB) | (32'(rf) << cdv_pkg::REF_LSB);
   endfunction : mk

   // configure, read back, then time every output
   task automatic run(int sel, int s2, int s1, int pr, int fb, int rf);
      int f[7];
      f = '{rf, fb, pr, s1, s1, s2, s2};
      wr(cdv_pkg::CFG_OFF, mk(sel, s2, s1, pr, fb, rf));
      wr(cdv_pkg::STAT_OFF, 32'hFFFFFFFF);
      rd(cdv_pkg::CFG_OFF, got);
      `CHK("cfg", mk(sel, s2, s1, pr, fb, rf), got)
      for (int i = 0; i < 7; i++) meas(i, f[i]);
   endtask : run

   // phase delay from phase 0 to primary rise, in cycles modulo the period
   task automatic pdel(input int sel, output int d);
      time t0;
      wr(cdv_pkg::CFG_OFF, mk(sel, 0, 0, 0, 0, 0));
      repeat (40) @(posedge clk);
      @(posedge phase_in[0]);
      t0 = $time;
      rise(2);
      d = int'(($time - t0 + 7) / 8) % 16;
   endtask : pdel

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : wrap_up

   initial begin
      repeat (15) @(posedge clk);
      #1 `CHK("outs in reset", 7'h00, outs)
      @(posedge clk);
      rst <= 1'b0;
      rd(cdv_pkg::CFG_OFF, got);
      `CHK("cfg reset", cdv_pkg::CFG_RESET, got)
      @(posedge clk); #1 `CHK("rd idle", 32'h00000000, rd_data)
      rd(8'h08, got);
      `CHK("unmapped", 32'h00000000, got)
      run(0, 31, 0, 5, 127, 0);
      run(0, 0, 31, 0, 0, 127);
      run(0, 2, 1, 31, 3, 1);
      pdel(0, d0);
      for (int s = 1; s < 8; s++) begin
         pdel(s, dk);
         `CHK("phase delay", (d0 + 4 * (s % 4)) % 16, dk)
         rd(cdv_pkg::STAT_OFF, got);
         `CHK("phase status", 2'(s % 4), got[9:8])
      end
      // mid-run reset brings back the reset configuration
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      #1 `CHK("outs mid reset", 7'h00, outs)
      @(posedge clk);
      rst <= 1'b0;
      rd(cdv_pkg::CFG_OFF, got);
      `CHK("cfg after reset", cdv_pkg::CFG_RESET, got)
      wrap_up();
   end
endmodule : tb_cdv_top
